// ==== hw/tmrb_register_bank.sv ====
// Register bank of a dual-channel temperature monitor
`timescale 1ns/1ps
module tmrb_register_bank #(
  parameter bit LOCAL_CRIT_HOT = 1'b0,
  // Arbitrary identity values
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] DIE_REV = 8'h0c,
  parameter int unsigned SLOWEST_CYCLES = tmrb_pkg::SLOWEST_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [9:0] local_raw,
  input wire logic [12:0] remote_raw,
  input wire logic remote_open,
  output logic busy,
  output logic [1:0] filter_level,
  output logic alert_oe,
  output logic tcrit_oe
);
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi_hi;
    logic [7:0] rlo_hi;
    logic [7:0] rhi_lo;
    logic [7:0] rlo_lo;
    logic [7:0] ofs_hi;
    logic [7:0] ofs_lo;
    logic [7:0] remote_critical_flag;
    logic [7:0] local_critical_flag;
    logic [7:0] hyst;
    logic [7:0] filt;
    logic [7:0] loc_t;
    logic [7:0] rem_hi;
    logic [7:0] rem_lo;
    logic [12:0] rem_val;
    logic [7:0] lo_frozen;
    logic frz_valid;
    logic [6:0] flags;
    logic [6:0] live;
    logic open_seen;
    logic busy;
    logic one_shot;
    logic [31:0] timer;
    logic start;
    logic eval1;
    logic eval2;
    logic [7:0] rd_data;
    logic local_critical_flag_act;
    logic remote_critical_flag_act;
    logic alert;
    logic tcrit;
  } tmrb_state_t;

  localparam logic [7:0] LOCAL_CRITICAL_FLAG_RST =
    LOCAL_CRIT_HOT ? tmrb_pkg::RST_LOCAL_CRITICAL_FLAG_HOT : tmrb_pkg::RST_LOCAL_CRITICAL_FLAG_STD;

  tmrb_state_t st_r;
  tmrb_state_t st_nxt;
  logic q_rover;
  logic q_runder;
  logic q_remote_critical_flag;
  logic v_rover;
  logic v_runder;
  logic v_remote_critical_flag;
  logic signed [12:0] rem_s;
  logic signed [12:0] rhi_s;
  logic signed [12:0] rlo_s;
  logic signed [12:0] remote_critical_flag_s;
  logic signed [8:0] loc_s;
  logic signed [13:0] rem_sum;
  logic signed [13:0] rem_sat;
  logic signed [13:0] rem_under;
  logic signed [9:0] loc_sat;
  logic [7:0] rate_code;
  logic [31:0] period;

  // Remote comparisons in eighths of a degree
  always_comb
  begin
    rem_s = $signed(st_r.rem_val);
    rhi_s = $signed({{2{st_r.rhi_hi[7]}}, st_r.rhi_hi, st_r.rhi_lo[7:5]});
    rlo_s = $signed({{2{st_r.rlo_hi[7]}}, st_r.rlo_hi, st_r.rlo_lo[7:5]});
    remote_critical_flag_s = $signed({{2{st_r.remote_critical_flag[7]}}, st_r.remote_critical_flag, 3'h0});
    loc_s = $signed({st_r.loc_t[7], st_r.loc_t});
    v_rover = rem_s > rhi_s;
    v_runder = rem_s < rlo_s;
    v_remote_critical_flag = rem_s > remote_critical_flag_s;
  end

  // Remote measurement with offset, clamped
  always_comb
  begin
    rem_sum = $signed({remote_raw[12], remote_raw})
      + $signed({{3{st_r.ofs_hi[7]}}, st_r.ofs_hi, st_r.ofs_lo[7:5]});
    if (rem_sum > tmrb_pkg::REM_MAX)
      rem_sat = tmrb_pkg::REM_MAX;
    else if (rem_sum < tmrb_pkg::REM_MIN)
      rem_sat = tmrb_pkg::REM_MIN;
    else
      rem_sat = rem_sum;
    rem_under = tmrb_pkg::REM_HI_FLOOR - rem_sat;
    if ($signed(local_raw) > tmrb_pkg::LOC_MAX)
      loc_sat = tmrb_pkg::LOC_MAX;
    else if ($signed(local_raw) < tmrb_pkg::LOC_MIN)
      loc_sat = tmrb_pkg::LOC_MIN;
    else
      loc_sat = $signed(local_raw);
  end

  // Codes above the defined range run at the fastest rate
  always_comb
  begin
    rate_code = (st_r.rate > tmrb_pkg::RATE_MAX_CODE) ? tmrb_pkg::RATE_MAX_CODE : st_r.rate;
    period = 32'(SLOWEST_CYCLES) >> rate_code;
  end

  tmrb_fault_queue #(
    .DEPTH(tmrb_pkg::FAULT_QUEUE_DEPTH)
  ) u_fq_over (
    .mclk(mclk),
    .resetn(resetn),
    .sample(st_r.eval1),
    .violation(v_rover),
    .enable(st_r.cfg[tmrb_pkg::CFG_FAULT_QUEUE]),
    .tripped(q_rover)
  );

  tmrb_fault_queue #(
    .DEPTH(tmrb_pkg::FAULT_QUEUE_DEPTH)
  ) u_fq_under (
    .mclk(mclk),
    .resetn(resetn),
    .sample(st_r.eval1),
    .violation(v_runder),
    .enable(st_r.cfg[tmrb_pkg::CFG_FAULT_QUEUE]),
    .tripped(q_runder)
  );

  tmrb_fault_queue #(
    .DEPTH(tmrb_pkg::FAULT_QUEUE_DEPTH)
  ) u_fq_crit (
    .mclk(mclk),
    .resetn(resetn),
    .sample(st_r.eval1),
    .violation(v_remote_critical_flag),
    .enable(st_r.cfg[tmrb_pkg::CFG_FAULT_QUEUE]),
    .tripped(q_remote_critical_flag)
  );

  always_comb
  begin
    logic [6:0] set_vec;
    logic [6:0] src;
    logic signed [9:0] lrel;
    logic signed [9:0] rrel;
    set_vec = 7'h00;
    src = 7'h00;
    lrel = 10'sd0;
    rrel = 10'sd0;
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.eval1 = 1'b0;
    st_nxt.eval2 = st_r.eval1;

    if (cmd_valid)
      st_nxt.ptr = cmd_byte;

    if (wr_valid)
    begin
      unique case (st_r.ptr)
        tmrb_pkg::A_CFG_WR: st_nxt.cfg = wr_data & tmrb_pkg::CFG_DEFINED;
        tmrb_pkg::A_RATE_WR: st_nxt.rate = wr_data;
        tmrb_pkg::A_LHI_WR: st_nxt.lhi = wr_data;
        tmrb_pkg::A_LLO_WR: st_nxt.llo = wr_data;
        tmrb_pkg::A_RHI_WR: st_nxt.rhi_hi = wr_data;
        tmrb_pkg::A_RLO_WR: st_nxt.rlo_hi = wr_data;
        tmrb_pkg::A_ONE_SHOT: st_nxt.one_shot = 1'b1;
        tmrb_pkg::A_OFS_HI: st_nxt.ofs_hi = wr_data;
        tmrb_pkg::A_OFS_LO: st_nxt.ofs_lo = wr_data & tmrb_pkg::FRAC_DEFINED;
        tmrb_pkg::A_RHI_LO: st_nxt.rhi_lo = wr_data & tmrb_pkg::FRAC_DEFINED;
        tmrb_pkg::A_RLO_LO: st_nxt.rlo_lo = wr_data & tmrb_pkg::FRAC_DEFINED;
        tmrb_pkg::A_REMOTE_CRITICAL_FLAG: st_nxt.remote_critical_flag = wr_data;
        tmrb_pkg::A_LOCAL_CRITICAL_FLAG: st_nxt.local_critical_flag = wr_data;
        tmrb_pkg::A_HYST: st_nxt.hyst = wr_data & tmrb_pkg::HYST_DEFINED;
        tmrb_pkg::A_FILT: st_nxt.filt = wr_data & tmrb_pkg::FILT_DEFINED;
        default: ;
      endcase
    end

    if (rd_req)
    begin
      unique case (st_r.ptr)
        tmrb_pkg::A_LOCAL_TEMP: st_nxt.rd_data = st_r.loc_t;
        tmrb_pkg::A_REMOTE_HI:
        begin
          st_nxt.rd_data = st_r.rem_hi;
          st_nxt.lo_frozen = st_r.rem_lo;
          st_nxt.frz_valid = 1'b1;
        end
        tmrb_pkg::A_STATUS: st_nxt.rd_data = {st_r.busy, st_r.flags};
        tmrb_pkg::A_CFG_RD: st_nxt.rd_data = st_r.cfg;
        tmrb_pkg::A_RATE_RD: st_nxt.rd_data = st_r.rate;
        tmrb_pkg::A_LHI_RD: st_nxt.rd_data = st_r.lhi;
        tmrb_pkg::A_LLO_RD: st_nxt.rd_data = st_r.llo;
        tmrb_pkg::A_RHI_RD: st_nxt.rd_data = st_r.rhi_hi;
        tmrb_pkg::A_RLO_RD: st_nxt.rd_data = st_r.rlo_hi;
        tmrb_pkg::A_REMOTE_LO:
        begin
          st_nxt.rd_data = st_r.frz_valid ? st_r.lo_frozen : st_r.rem_lo;
          st_nxt.frz_valid = 1'b0;
        end
        tmrb_pkg::A_OFS_HI: st_nxt.rd_data = st_r.ofs_hi;
        tmrb_pkg::A_OFS_LO: st_nxt.rd_data = st_r.ofs_lo;
        tmrb_pkg::A_RHI_LO: st_nxt.rd_data = st_r.rhi_lo;
        tmrb_pkg::A_RLO_LO: st_nxt.rd_data = st_r.rlo_lo;
        tmrb_pkg::A_REMOTE_CRITICAL_FLAG: st_nxt.rd_data = st_r.remote_critical_flag;
        tmrb_pkg::A_LOCAL_CRITICAL_FLAG: st_nxt.rd_data = st_r.local_critical_flag;
        tmrb_pkg::A_HYST: st_nxt.rd_data = st_r.hyst;
        tmrb_pkg::A_FILT: st_nxt.rd_data = st_r.filt;
        tmrb_pkg::A_MAKER: st_nxt.rd_data = MAKER_CODE;
        tmrb_pkg::A_REV: st_nxt.rd_data = DIE_REV;
        default: st_nxt.rd_data = 8'h00;
      endcase
    end

    // Conversion scheduling; a one-shot still runs in shutdown
    if (st_r.cfg[tmrb_pkg::CFG_SHUTDOWN])
      st_nxt.timer = 32'h0;
    else if (st_r.timer < period - 32'h1)
      st_nxt.timer = st_r.timer + 32'h1;
    // A start still in flight counts as busy, so no second start follows it
    if (!st_r.busy && !st_r.start)
    begin
      if (st_r.one_shot)
      begin
        st_nxt.start = 1'b1;
        st_nxt.one_shot = 1'b0;
      end
      else if (!st_r.cfg[tmrb_pkg::CFG_SHUTDOWN] && st_r.timer >= period - 32'h1)
      begin
        st_nxt.start = 1'b1;
        st_nxt.timer = 32'h0;
      end
    end
    if (st_r.start)
      st_nxt.busy = 1'b1;
    else if (conv_done)
      st_nxt.busy = 1'b0;

    // Results replace the reset zeros only when a conversion ends
    if (conv_done && st_r.busy)
    begin
      st_nxt.loc_t = loc_sat[7:0];
      st_nxt.rem_val = rem_sat[12:0];
      if (rem_sat < tmrb_pkg::REM_HI_FLOOR)
      begin
        st_nxt.rem_hi = 8'h80;
        st_nxt.rem_lo = {rem_under[2:0], 5'h00};
      end
      else
      begin
        st_nxt.rem_hi = rem_sat[10:3];
        st_nxt.rem_lo = {rem_sat[2:0], 5'h00};
      end
      st_nxt.open_seen = remote_open;
      st_nxt.eval1 = 1'b1;
    end

    // Alarm update one cycle after the fault queues sample
    if (st_r.eval2)
    begin
      lrel = $signed({st_r.local_critical_flag[7], st_r.local_critical_flag[7], st_r.local_critical_flag})
        - $signed({2'h0, st_r.hyst});
      rrel = $signed({st_r.remote_critical_flag[7], st_r.remote_critical_flag[7], st_r.remote_critical_flag})
        - $signed({2'h0, st_r.hyst});
      st_nxt.live[tmrb_pkg::ST_LOVER] = loc_s > $signed({st_r.lhi[7], st_r.lhi});
      st_nxt.live[tmrb_pkg::ST_LUNDER] = loc_s < $signed({st_r.llo[7], st_r.llo});
      st_nxt.live[tmrb_pkg::ST_ROVER] = q_rover;
      st_nxt.live[tmrb_pkg::ST_RUNDER] = q_runder;
      st_nxt.live[tmrb_pkg::ST_OPEN] = st_r.open_seen;
      st_nxt.live[tmrb_pkg::ST_REMOTE_CRITICAL_FLAG] = q_remote_critical_flag;
      st_nxt.live[tmrb_pkg::ST_LOCAL_CRITICAL_FLAG] = loc_s > $signed({st_r.local_critical_flag[7], st_r.local_critical_flag});
      set_vec = st_nxt.live;
      // Critical outputs release only at or below the limit minus hysteresis
      st_nxt.local_critical_flag_act = st_nxt.live[tmrb_pkg::ST_LOCAL_CRITICAL_FLAG]
        | (st_r.local_critical_flag_act & ($signed({loc_s[8], loc_s}) > lrel));
      st_nxt.remote_critical_flag_act = q_remote_critical_flag
        | (st_r.remote_critical_flag_act & ($signed({st_r.rem_hi[7], st_r.rem_hi[7], st_r.rem_hi}) > rrel));
    end

    // A flag raised in the clearing cycle survives the status read
    if (rd_req && st_r.ptr == tmrb_pkg::A_STATUS)
      st_nxt.flags = set_vec;
    else
      st_nxt.flags = st_r.flags | set_vec;

    // Disconnect does not drive the alert
    src = st_r.filt[tmrb_pkg::FILT_CMP_MODE] ? st_r.live : st_r.flags;
    st_nxt.alert = !st_r.cfg[tmrb_pkg::CFG_ALERT_MASK]
      && |(src & tmrb_pkg::ALERT_SOURCES);
    st_nxt.tcrit = (st_r.local_critical_flag_act && !st_r.cfg[tmrb_pkg::CFG_LOCAL_CRITICAL_FLAG_MASK])
      || (st_r.remote_critical_flag_act && !st_r.cfg[tmrb_pkg::CFG_REMOTE_CRITICAL_FLAG_MASK]);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.ptr <= tmrb_pkg::RST_POINTER;
      st_r.loc_t <= tmrb_pkg::RST_TEMP;
      st_r.rem_hi <= tmrb_pkg::RST_TEMP;
      st_r.rem_lo <= tmrb_pkg::RST_TEMP;
      st_r.flags <= tmrb_pkg::RST_FLAGS;
      st_r.cfg <= tmrb_pkg::RST_CFG;
      st_r.remote_critical_flag <= tmrb_pkg::RST_REMOTE_CRITICAL_FLAG;
      st_r.local_critical_flag <= LOCAL_CRITICAL_FLAG_RST;
      st_r.lhi <= tmrb_pkg::RST_HIGH;
      st_r.rhi_hi <= tmrb_pkg::RST_HIGH;
      st_r.llo <= tmrb_pkg::RST_LOW;
      st_r.rlo_hi <= tmrb_pkg::RST_LOW;
      st_r.rhi_lo <= tmrb_pkg::RST_FRAC;
      st_r.rlo_lo <= tmrb_pkg::RST_FRAC;
      st_r.ofs_hi <= tmrb_pkg::RST_OFS;
      st_r.ofs_lo <= tmrb_pkg::RST_OFS;
      st_r.hyst <= tmrb_pkg::RST_HYST;
      st_r.filt <= tmrb_pkg::RST_FILT;
      st_r.rate <= tmrb_pkg::RST_RATE;
    end
    else
      st_r <= st_nxt;
  end

  assign rd_data = st_r.rd_data;
  assign conv_start = st_r.start;
  assign busy = st_r.busy;
  assign filter_level = st_r.filt[2:1];
  assign alert_oe = st_r.alert;
  assign tcrit_oe = st_r.tcrit;
endmodule : tmrb_register_bank

// ==== hw/tmrb_pkg.sv ====
// Constants shared by the temperature monitor register bank
package tmrb_pkg;
  // Pointer values
  localparam logic [7:0] A_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] A_REMOTE_HI = 8'h01;
  localparam logic [7:0] A_STATUS = 8'h02;
  localparam logic [7:0] A_CFG_RD = 8'h03;
  localparam logic [7:0] A_RATE_RD = 8'h04;
  localparam logic [7:0] A_LHI_RD = 8'h05;
  localparam logic [7:0] A_LLO_RD = 8'h06;
  localparam logic [7:0] A_RHI_RD = 8'h07;
  localparam logic [7:0] A_RLO_RD = 8'h08;
  localparam logic [7:0] A_CFG_WR = 8'h09;
  localparam logic [7:0] A_RATE_WR = 8'h0a;
  localparam logic [7:0] A_LHI_WR = 8'h0b;
  localparam logic [7:0] A_LLO_WR = 8'h0c;
  localparam logic [7:0] A_RHI_WR = 8'h0d;
  localparam logic [7:0] A_RLO_WR = 8'h0e;
  localparam logic [7:0] A_ONE_SHOT = 8'h0f;
  localparam logic [7:0] A_REMOTE_LO = 8'h10;
  localparam logic [7:0] A_OFS_HI = 8'h11;
  localparam logic [7:0] A_OFS_LO = 8'h12;
  localparam logic [7:0] A_RHI_LO = 8'h13;
  localparam logic [7:0] A_RLO_LO = 8'h14;
  localparam logic [7:0] A_REMOTE_CRITICAL_FLAG = 8'h19;
  localparam logic [7:0] A_LOCAL_CRITICAL_FLAG = 8'h20;
  localparam logic [7:0] A_HYST = 8'h21;
  localparam logic [7:0] A_FILT = 8'hbf;
  localparam logic [7:0] A_MAKER = 8'hfe;
  localparam logic [7:0] A_REV = 8'hff;
  // Values after reset
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_TEMP = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h08;
  localparam logic [7:0] RST_HIGH = 8'h46;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [7:0] RST_FRAC = 8'h00;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [7:0] RST_REMOTE_CRITICAL_FLAG = 8'h6e;
  localparam logic [7:0] RST_LOCAL_CRITICAL_FLAG_STD = 8'h55;
  localparam logic [7:0] RST_LOCAL_CRITICAL_FLAG_HOT = 8'h69;
  localparam logic [7:0] RST_HYST = 8'h0a;
  localparam logic [7:0] RST_FILT = 8'h00;
  localparam logic [6:0] RST_FLAGS = 7'h00;
  // Field positions and masks
  localparam int CFG_ALERT_MASK = 7;
  localparam int CFG_SHUTDOWN = 6;
  localparam int CFG_REMOTE_CRITICAL_FLAG_MASK = 4;
  localparam int CFG_LOCAL_CRITICAL_FLAG_MASK = 2;
  localparam int CFG_FAULT_QUEUE = 0;
  localparam int ST_LOVER = 6;
  localparam int ST_LUNDER = 5;
  localparam int ST_ROVER = 4;
  localparam int ST_RUNDER = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_REMOTE_CRITICAL_FLAG = 1;
  localparam int ST_LOCAL_CRITICAL_FLAG = 0;
  localparam int FILT_CMP_MODE = 0;
  localparam logic [7:0] CFG_DEFINED = 8'hd5;
  localparam logic [7:0] FRAC_DEFINED = 8'he0;
  localparam logic [7:0] HYST_DEFINED = 8'h1f;
  localparam logic [7:0] FILT_DEFINED = 8'h07;
  localparam logic [6:0] ALERT_SOURCES = 7'h7b;
  // Conversion timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SLOWEST_PERIOD_S = 16;
  localparam int unsigned SLOWEST_CYCLES = CLK_HZ * SLOWEST_PERIOD_S;
  localparam logic [7:0] RATE_MAX_CODE = 8'h09;
  localparam int FAULT_QUEUE_DEPTH = 3;
  // Remote result range in eighths of a degree, local range in whole degrees
  localparam logic signed [13:0] REM_MAX = 14'sd1023;
  localparam logic signed [13:0] REM_MIN = -14'sd1031;
  localparam logic signed [13:0] REM_HI_FLOOR = -14'sd1024;
  localparam logic signed [9:0] LOC_MAX = 10'sd127;
  localparam logic signed [9:0] LOC_MIN = -10'sd128;
endpackage : tmrb_pkg

// ==== hw/tmrb_fault_queue.sv ====
// Consecutive out-of-limit counter for one remote comparison
`timescale 1ns/1ps
module tmrb_fault_queue #(
  parameter int DEPTH = tmrb_pkg::FAULT_QUEUE_DEPTH
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sample,
  input wire logic violation,
  input wire logic enable,
  output logic tripped
);
  typedef struct packed {
    logic [3:0] count;
    logic tripped;
  } tmrb_fq_state_t;

  tmrb_fq_state_t st_r;
  tmrb_fq_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (sample)
    begin
      if (!violation)
        st_nxt.count = 4'h0;
      else if (st_r.count < 4'(DEPTH))
        st_nxt.count = st_r.count + 4'h1;
      // Without the queue a single violation trips
      st_nxt.tripped = enable ? (st_nxt.count >= 4'(DEPTH)) : violation;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tripped = st_r.tripped;
endmodule : tmrb_fault_queue

// ==== tb/tmrb_register_bank_checker.sv ====
// Port-level assertions for the temperature monitor register bank
`timescale 1ns/1ps
module tmrb_register_bank_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic busy,
  input wire logic [1:0] filter_level
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_launch;
    conv_start ##1 busy;
  endsequence
  sequence s_finish;
    conv_done ##1 !busy;
  endsequence
  AST_START_BUSY: assert property (conv_start |-> s_launch)
    else $error("busy did not follow a start");
  AST_DONE_IDLE: assert property (busy && conv_done |-> s_finish)
    else $error("busy did not drop after done");
  AST_BUSY_HOLD: assert property (busy && !conv_done |=> busy)
    else $error("busy dropped without done");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(conv_start))
    else $error("busy rose without a start");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  AST_NO_START_BUSY: assert property (busy |-> !conv_start)
    else $error("start while busy");
  AST_RD_HOLD: assert property (!rd_req |=> $stable(rd_data))
    else $error("read data changed without a read");
  AST_FILT_CAUSE: assert property ($changed(filter_level) |-> $past(wr_valid) || $past(wr_valid, 2))
    else $error("filter level changed without a write");
endmodule : tmrb_register_bank_checker

bind tmrb_register_bank tmrb_register_bank_checker i_chk (.mclk, .resetn, .wr_valid, .rd_req,
  .rd_data, .conv_start, .conv_done, .busy, .filter_level);

// ==== tb/tmrb_host_model.sv ====
// Host model that selects, writes and reads registers
`timescale 1ns/1ps
module tmrb_host_model (
  input wire logic mclk,
  input wire logic [7:0] rd_data,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_req = 1'b0;
  end
  // Released bytes are inverted so stale values never look valid
  task automatic sel(input logic [7:0] a);
    @(negedge mclk) cmd_valid = 1'b1;
    cmd_byte = a;
    @(negedge mclk) cmd_valid = 1'b0;
    cmd_byte = ~a;
  endtask : sel
  task automatic put(input logic [7:0] v);
    @(negedge mclk) wr_valid = 1'b1;
    wr_data = v;
    @(negedge mclk) wr_valid = 1'b0;
    wr_data = ~v;
  endtask : put
  task automatic get(output logic [7:0] v);
    @(negedge mclk) rd_req = 1'b1;
    @(negedge mclk) rd_req = 1'b0;
    v = rd_data;
  endtask : get
endmodule : tmrb_host_model

// ==== tb/tmrb_register_bank_tb_top.sv ====
// Self-checking bench of the temperature monitor register bank
`timescale 1ns/1ps
module tmrb_register_bank_tb_top;
  localparam int unsigned SLOW = 5120;
  // Arbitrary identity values
  localparam logic [7:0] MAKER = 8'h3c;
  localparam logic [7:0] REV = 8'h07;
  logic mclk, resetn, cmd_valid, wr_valid, rd_req, conv_start, conv_done;
  logic remote_open, busy, alert_oe, tcrit_oe;
  logic [7:0] cmd_byte, wr_data, rd_data, d;
  logic [9:0] local_raw;
  logic [12:0] remote_raw;
  logic [1:0] filter_level;
  logic [7:0] m [256];
  logic [31:0] lfsr = 32'hb76e;
  logic [7:0] ra [22] = '{8'h02, 8'h00, 8'h01, 8'h10, 8'h0f, 8'h30, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'hbf, 8'hfe, 8'hff, 8'h21};
  logic [7:0] wa [20] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h19, 8'h20, 8'h21, 8'hbf, 8'h03, 8'h00, 8'h02, 8'hb5, 8'hfe, 8'hff};
  int n_mismatch = 0, tests_run = 0, cyc = 0, cnt = 0, lat = 300;
  int starts = 0, iv = 0, last = 0, s0, p;
  tmrb_register_bank #(.SLOWEST_CYCLES(SLOW), .MAKER_CODE(MAKER), .DIE_REV(REV)) i_dut (.mclk,
    .resetn, .cmd_valid, .cmd_byte, .wr_valid, .wr_data, .rd_req, .rd_data, .conv_start,
    .conv_done, .local_raw, .remote_raw, .remote_open, .busy, .filter_level, .alert_oe, .tcrit_oe);
  tmrb_host_model i_host (.mclk, .rd_data, .cmd_valid, .cmd_byte, .wr_valid, .wr_data, .rd_req);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  // Converter stand-in; a long latency keeps results at zero early on
  always @(negedge mclk)
  begin
    conv_done <= 1'b0;
    if (conv_start === 1'b1)
    begin
      cnt = lat;
      starts++;
      iv = cyc - last;
      last = cyc;
    end
    else if (cnt > 0)
    begin
      cnt--;
      if (cnt == 0) conv_done <= 1'b1;
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pin(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : pin
  task automatic rdc(input logic [7:0] a);
    i_host.sel(a);
    i_host.get(d);
    chk($sformatf("reg %h", a), m[a], d);
  endtask : rdc
  task automatic st(input logic [7:0] e);
    m[8'h02] = e;
    rdc(8'h02);
  endtask : st
  task automatic res();
    rdc(8'h00);
    rdc(8'h01);
    rdc(8'h10);
  endtask : res
  task automatic wrm(input logic [7:0] a, input logic [7:0] v);
    i_host.sel(a);
    i_host.put(v);
    if (a >= 8'h09 && a <= 8'h0e) m[a - 8'h06] = (a == 8'h09) ? v & 8'hd5 : v;
    else if (a inside {8'h11, 8'h19, 8'h20}) m[a] = v;
    else if (a inside {8'h12, 8'h13, 8'h14}) m[a] = v & 8'he0;
    else if (a == 8'h21) m[a] = v & 8'h1f;
    else if (a == 8'hbf) m[a] = v & 8'h07;
  endtask : wrm
  task automatic do_reset();
    @(negedge mclk) resetn = 1'b0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    foreach (m[i]) m[i] = 8'h00;
    m[8'h04] = 8'h08;
    m[8'h05] = 8'h46;
    m[8'h07] = 8'h46;
    m[8'h19] = 8'h6e;
    m[8'h20] = 8'h55;
    m[8'h21] = 8'h0a;
    m[8'hfe] = MAKER;
    m[8'hff] = REV;
  endtask : do_reset
  task automatic conv(input int lr, input int rr, input logic op);
    int r;
    local_raw = 10'(lr);
    remote_raw = 13'(rr);
    remote_open = op;
    r = rr < -1031 ? -1031 : (rr > 1023 ? 1023 : rr);
    m[8'h00] = 8'(lr < -128 ? -128 : (lr > 127 ? 127 : lr));
    m[8'h01] = r < -1024 ? 8'h80 : 8'(r >>> 3);
    m[8'h10] = 8'((r < -1024 ? -1024 - r : r & 7) << 5);
    wrm(8'h0f, 8'h00);
    for (int i = 0; i < 50 && conv_done !== 1'b1; i++) @(negedge mclk);
    repeat (5) @(negedge mclk);
  endtask : conv
  initial
  begin
    resetn = 1'b0;
    remote_open = 1'b0;
    local_raw = 10'h000;
    remote_raw = 13'h0000;
    do_reset();
    i_host.get(d);
    chk("reset pointer", 8'h00, d);
    foreach (ra[i]) rdc(ra[i]);
    i_host.get(d);
    chk("held pointer", m[8'h21], d);
    lat = 4;
    foreach (wa[i])
    begin
      lfsr = nx(lfsr);
      wrm(wa[i], lfsr[7:0]);
    end
    for (int i = 6; i < 22; i++) rdc(ra[i]);
    chk("filter level", {6'h00, m[8'hbf][2:1]}, {6'h00, filter_level});
    do_reset();
    wrm(8'h09, 8'h40);
    s0 = starts;
    repeat (100) @(negedge mclk);
    chk("starts in shutdown", 8'(s0), 8'(starts));
    conv(200, -2000, 1'b0);
    res();
    st(8'h49);
    conv(-200, 3000, 1'b0);
    res();
    pin("crit pin", 1'b1, tcrit_oe);
    st(8'h32);
    conv(25, 203, 1'b1);
    res();
    pin("crit pin", 1'b0, tcrit_oe);
    st(8'h04);
    rdc(8'h01);
    conv(25, 205, 1'b0);
    i_host.sel(8'h10);
    i_host.get(d);
    chk("frozen low byte", 8'h60, d);
    rdc(8'h10);
    wrm(8'h09, 8'hc0);
    conv(80, 0, 1'b0);
    pin("alert pin", 1'b0, alert_oe);
    st(8'h40);
    wrm(8'h09, 8'h40);
    conv(80, 0, 1'b0);
    pin("alert pin", 1'b1, alert_oe);
    wrm(8'h09, 8'h44);
    conv(90, 0, 1'b0);
    pin("crit pin", 1'b0, tcrit_oe);
    wrm(8'h09, 8'h40);
    conv(90, 0, 1'b0);
    pin("crit pin", 1'b1, tcrit_oe);
    conv(25, 0, 1'b0);
    i_host.sel(8'h02);
    i_host.get(d);
    wrm(8'h09, 8'h41);
    conv(25, 800, 1'b0);
    conv(25, 800, 1'b0);
    st(8'h00);
    conv(25, 800, 1'b0);
    st(8'h10);
    // Comparator mode keeps alert up after the status read while the alarm is live
    wrm(8'hbf, 8'h01);
    @(negedge mclk);
    pin("alert pin", 1'b1, alert_oe);
    conv(25, 0, 1'b0);
    pin("alert pin", 1'b0, alert_oe);
    wrm(8'h09, 8'h00);
    for (int c = 0; c <= 10; c++)
    begin
      wrm(8'h0a, 8'(c));
      s0 = starts;
      while (starts < s0 + 2) @(negedge mclk);
      p = SLOW >> (c > 9 ? 9 : c);
      pin($sformatf("rate %0d period", c), 1'b1, iv >= p - 2 && iv <= p + 2);
    end
    finish_test();
  end
endmodule : tmrb_register_bank_tb_top
